// [rtl/ccs_pkg.sv]
// package: offsets, field layout, reset values and current weights of the charge current bank
// assumes: included first; all design files import it whole
package ccs_pkg;
   localparam logic [6:0] CCS_DEV_ADDR = 7'h6b;
   localparam logic [7:0] CCS_OFS_FAST = 8'h02;
   localparam logic [7:0] CCS_OFS_PT = 8'h03;
   localparam logic [7:0] CCS_FAST_RST = 8'h20;
   localparam logic [7:0] CCS_PT_RST = 8'h11;
   localparam int CCS_FAST_CODE_HI = 7;
   localparam int CCS_FAST_CODE_LO = 2;
   localparam int CCS_RSVD_BIT = 1;
   localparam int CCS_FORCE_BIT = 0;
   localparam int CCS_PRE_CODE_HI = 7;
   localparam int CCS_PRE_CODE_LO = 4;
   localparam int CCS_TERM_CODE_HI = 3;
   localparam int CCS_TERM_CODE_LO = 0;
   localparam int CCS_MA_W = 13;
   localparam logic [12:0] CCS_FAST_OFS_MA = 13'h0200;
   localparam logic [12:0] CCS_PT_OFS_MA = 13'h0080;
   localparam int CCS_FAST_LSB_SHIFT = 6;
   localparam int CCS_PT_LSB_SHIFT = 7;
   localparam logic [12:0] CCS_FAST_REDUCE_DIV = 13'h0005;
   localparam int CCS_PRE_REDUCE_SHIFT = 1;

   typedef struct packed {
      logic [12:0] fastMa;
      logic [12:0] prechgMa;
      logic [12:0] termMa;
   } ccs_currents_t;
endpackage

// [rtl/ccs_current_decode.sv]
// current decoder: turns the two control bytes into registered target currents in mA
// assumes: same clock and synchronised reset as the register bank
`timescale 1ns/1ps
module ccs_current_decode
   import ccs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstN,
   // register contents
   input wire logic [7:0] fastReg,
   input wire logic [7:0] ptReg,
   // decoded targets
   output ccs_currents_t currents
);
   logic [12:0] fastFullMa;
   logic [12:0] preFullMa;
   logic [12:0] termFullMa;
   logic forceReduced;

   assign forceReduced = fastReg[CCS_FORCE_BIT];
   assign fastFullMa = CCS_FAST_OFS_MA +
      ({7'h00, fastReg[CCS_FAST_CODE_HI:CCS_FAST_CODE_LO]} << CCS_FAST_LSB_SHIFT);
   assign preFullMa = CCS_PT_OFS_MA +
      ({9'h000, ptReg[CCS_PRE_CODE_HI:CCS_PRE_CODE_LO]} << CCS_PT_LSB_SHIFT);
   assign termFullMa = CCS_PT_OFS_MA +
      ({9'h000, ptReg[CCS_TERM_CODE_HI:CCS_TERM_CODE_LO]} << CCS_PT_LSB_SHIFT);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         currents <= '0;
      end else begin
         currents.fastMa <= forceReduced ? 13'(fastFullMa / CCS_FAST_REDUCE_DIV) : fastFullMa;
         currents.prechgMa <= forceReduced ? (preFullMa >> CCS_PRE_REDUCE_SHIFT) : preFullMa;
         currents.termMa <= termFullMa;
      end
   end

   AST_FAST_DECODE: assert property (@(posedge clk) disable iff (!rstN)
      rstN && !fastReg[CCS_FORCE_BIT] |=> currents.fastMa ==
      13'd512 + 13'(({7'h00, $past(fastReg[7:2])}) * 13'd64))
      else $error("fast charge current decode wrong");
   AST_REDUCED: assert property (@(posedge clk) disable iff (!rstN)
      rstN && fastReg[CCS_FORCE_BIT] |=> (currents.fastMa ==
      13'((13'd512 + 13'(({7'h00, $past(fastReg[7:2])}) * 13'd64)) / 13'd5)) &&
      (currents.prechgMa ==
      ((13'd128 + 13'(({9'h000, $past(ptReg[7:4])}) * 13'd128)) >> 1)))
      else $error("reduced current not applied");
   AST_PRE_DECODE: assert property (@(posedge clk) disable iff (!rstN)
      rstN && !fastReg[CCS_FORCE_BIT] |=> currents.prechgMa ==
      13'd128 + 13'(({9'h000, $past(ptReg[7:4])}) * 13'd128))
      else $error("precharge current decode wrong");
   AST_TERM_DECODE: assert property (@(posedge clk) disable iff (!rstN)
      rstN |=> currents.termMa == 13'd128 + 13'(({9'h000, $past(ptReg[3:0])}) * 13'd128))
      else $error("termination current decode wrong");
endmodule

// [rtl/ccs_charge_current_regs.sv]
// charge current register bank with its own two-wire serial slave and current decoder
// assumes: serial pins are asynchronous to clk; testbench resolves the open-drain data wire
// Function
// - bits 7..2 of the fast charge register are a code of 64 mA steps added to 512 mA.
// - the fast charge code resets to 001000 (1024 mA) and spans 512 mA to 4544 mA.
// - with the force bit set the fast target is 20 % and precharge 50 %, else unchanged.
// - bits 7..4 of the second register are a precharge code of 128 mA steps over 128 mA.
// - bits 3..0 of the second register are a termination code of 128 mA steps over 128 mA.
// - the precharge/termination register resets to 00010001.
// - both registers are read and written over the serial bus at slave address 6bh.
`timescale 1ns/1ps
module ccs_charge_current_regs
   import ccs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial bus pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   // decoded targets to charge control
   output ccs_currents_t currents
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } ccs_state_t;

   logic [1:0] rstPipe_q;
   logic rstSyncN;
   logic [1:0] sclPipe_q;
   logic [1:0] sdaPipe_q;
   logic sclPrev_q;
   logic sdaPrev_q;
   logic sclS;
   logic sdaS;
   logic busStart;
   logic busStop;
   logic sclRise;
   logic sclFall;
   ccs_state_t st_q;
   logic [2:0] bitCnt_q;
   logic byteDone_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic mAck_q;
   logic wrEn_q;
   logic [7:0] wrAddr_q;
   logic [7:0] wrData_q;
   logic [7:0] fastReg_q;
   logic [7:0] ptReg_q;
   logic [7:0] rdByte;
   logic inByte;

   // reset release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstPipe_q <= 2'h0;
      end else begin
         rstPipe_q <= {rstPipe_q[0], 1'b1};
      end
   end
   assign rstSyncN = rstPipe_q[1];

   // pin synchronisers and edge history
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         sclPipe_q <= 2'h3;
         sdaPipe_q <= 2'h3;
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclPipe_q <= {sclPipe_q[0], scl};
         sdaPipe_q <= {sdaPipe_q[0], sdaIn};
         sclPrev_q <= sclPipe_q[1];
         sdaPrev_q <= sdaPipe_q[1];
      end
   end
   assign sclS = sclPipe_q[1];
   assign sdaS = sdaPipe_q[1];
   assign busStart = sclS && sclPrev_q && sdaPrev_q && !sdaS;
   assign busStop = sclS && sclPrev_q && !sdaPrev_q && sdaS;
   assign sclRise = sclS && !sclPrev_q;
   assign sclFall = !sclS && sclPrev_q;
   assign inByte = (st_q == ST_ADDR) || (st_q == ST_PTR) || (st_q == ST_WR);

   // read mux, unmapped offsets read zero
   always_comb begin
      rdByte = 8'h00;
      if (ptr_q == CCS_OFS_FAST) begin
         rdByte = fastReg_q;
      end else if (ptr_q == CCS_OFS_PT) begin
         rdByte = ptReg_q;
      end
   end

   // serial slave sequencer
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         st_q <= ST_IDLE;
         bitCnt_q <= 3'h0;
         byteDone_q <= 1'b0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         mAck_q <= 1'b0;
         sdaOeN <= 1'b1;
         wrEn_q <= 1'b0;
         wrAddr_q <= 8'h00;
         wrData_q <= 8'h00;
      end else begin
         wrEn_q <= 1'b0;
         if (busStop) begin
            st_q <= ST_IDLE;
            sdaOeN <= 1'b1;
         end else if (busStart) begin
            st_q <= ST_ADDR;
            bitCnt_q <= 3'h0;
            byteDone_q <= 1'b0;
            sdaOeN <= 1'b1;
         end else begin
            if (sclRise && inByte) begin
               shift_q <= {shift_q[6:0], sdaS};
               bitCnt_q <= bitCnt_q + 3'h1;
               if (bitCnt_q == 3'h7) begin
                  byteDone_q <= 1'b1;
               end
            end
            if (sclRise && st_q == ST_RD_ACK) begin
               mAck_q <= !sdaS;
            end
            if (sclFall) begin
               unique case (st_q)
                  ST_IDLE: begin
                  end
                  ST_ADDR: begin
                     if (byteDone_q) begin
                        byteDone_q <= 1'b0;
                        if (shift_q[7:1] == CCS_DEV_ADDR) begin
                           st_q <= ST_ADDR_ACK;
                           sdaOeN <= 1'b0;
                           rw_q <= shift_q[0];
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end
                  end
                  ST_ADDR_ACK: begin
                     if (rw_q) begin
                        shift_q <= rdByte;
                        sdaOeN <= rdByte[7];
                        bitCnt_q <= 3'h0;
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= ST_RD;
                     end else begin
                        sdaOeN <= 1'b1;
                        st_q <= ST_PTR;
                     end
                  end
                  ST_PTR: begin
                     if (byteDone_q) begin
                        byteDone_q <= 1'b0;
                        ptr_q <= shift_q;
                        sdaOeN <= 1'b0;
                        st_q <= ST_PTR_ACK;
                     end
                  end
                  ST_PTR_ACK: begin
                     sdaOeN <= 1'b1;
                     st_q <= ST_WR;
                  end
                  ST_WR: begin
                     if (byteDone_q) begin
                        byteDone_q <= 1'b0;
                        wrEn_q <= 1'b1;
                        wrAddr_q <= ptr_q;
                        wrData_q <= shift_q;
                        ptr_q <= ptr_q + 8'h01;
                        sdaOeN <= 1'b0;
                        st_q <= ST_WR_ACK;
                     end
                  end
                  ST_WR_ACK: begin
                     sdaOeN <= 1'b1;
                     st_q <= ST_WR;
                  end
                  ST_RD: begin
                     if (bitCnt_q == 3'h7) begin
                        sdaOeN <= 1'b1;
                        bitCnt_q <= 3'h0;
                        st_q <= ST_RD_ACK;
                     end else begin
                        sdaOeN <= shift_q[6];
                        shift_q <= {shift_q[6:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 3'h1;
                     end
                  end
                  ST_RD_ACK: begin
                     if (mAck_q) begin
                        shift_q <= rdByte;
                        sdaOeN <= rdByte[7];
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= ST_RD;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               endcase
            end
         end
      end
   end

   // data pin level is always low when driven
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         sdaOut <= 1'b0;
      end else begin
         sdaOut <= 1'b0;
      end
   end

   // fast charge register, spare bit stored as written
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         fastReg_q <= CCS_FAST_RST;
      end else if (wrEn_q && wrAddr_q == CCS_OFS_FAST) begin
         fastReg_q <= wrData_q;
      end
   end

   // precharge and termination register
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ptReg_q <= CCS_PT_RST;
      end else if (wrEn_q && wrAddr_q == CCS_OFS_PT) begin
         ptReg_q <= wrData_q;
      end
   end

   ccs_current_decode uDecode (
      .clk(clk),
      .rstN(rstSyncN),
      .fastReg(fastReg_q),
      .ptReg(ptReg_q),
      .currents(currents)
   );

   sequence seqAddrMatch;
      sclFall && !busStart && !busStop && st_q == ST_ADDR && byteDone_q &&
         shift_q[7:1] == 7'h6b;
   endsequence

   AST_RESET_VALUES: assert property (@(posedge clk)
      $rose(rstSyncN) |-> fastReg_q == 8'h20 && ptReg_q == 8'h11)
      else $error("register reset values wrong");
   AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!rstSyncN)
      seqAddrMatch |=> !sdaOeN && st_q == ST_ADDR_ACK)
      else $error("own address not acknowledged");
   AST_ADDR_NOMATCH: assert property (@(posedge clk) disable iff (!rstSyncN)
      sclFall && !busStart && !busStop && st_q == ST_ADDR && byteDone_q &&
      shift_q[7:1] != 7'h6b |=> sdaOeN && st_q == ST_IDLE)
      else $error("foreign address answered");
   AST_FAST_WRITE: assert property (@(posedge clk) disable iff (!rstSyncN)
      wrEn_q && wrAddr_q == 8'h02 |=> fastReg_q == $past(wrData_q))
      else $error("fast register write lost");
   AST_PT_WRITE: assert property (@(posedge clk) disable iff (!rstSyncN)
      wrEn_q && wrAddr_q == 8'h03 |=> ptReg_q == $past(wrData_q))
      else $error("second register write lost");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rstSyncN)
      !wrEn_q |=> $stable(fastReg_q) && $stable(ptReg_q))
      else $error("register changed without write");
   AST_WRITE_PULSE: assert property (@(posedge clk) disable iff (!rstSyncN)
      wrEn_q |=> !wrEn_q && st_q == ST_WR_ACK && !sdaOeN)
      else $error("write strobe not single cycle with ack");
endmodule

// [verification/ccs_host_model.sv]
// host model: two-wire serial master reaching the charge current registers
// assumes: bench resolves the open-drain data wire and feeds it back as sda
`timescale 1ns/1ps
module ccs_host_model
   import ccs_pkg::*;
(
   // clock
   input wire logic clk,
   // serial bus
   output logic scl,
   output logic sdaLow,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic half();
      repeat (6) @(negedge clk);
   endtask
   task automatic bitx(input logic b, output logic s);
      sdaLow = !b;
      half();
      scl = 1'b1;
      s = sda;
      half();
      scl = 1'b0;
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic bytex(input logic [7:0] b, input logic mAck, output logic [7:0] r,
      output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(b[i], s);
         r[i] = s;
      end
      bitx(!mAck, s);
      ack = !s;
   endtask
   task automatic start();
      sdaLow = 1'b0;
      half();
      scl = 1'b1;
      half();
      sdaLow = 1'b1;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      sdaLow = 1'b1;
      half();
      scl = 1'b1;
      half();
      sdaLow = 1'b0;
      half();
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
      output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      bytex({dev, 1'b0}, 1'b0, r, a0);
      bytex(ptr, 1'b0, r, a1);
      bytex(d, 1'b0, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      start();
      bytex({CCS_DEV_ADDR, 1'b0}, 1'b0, r, a);
      bytex(ptr, 1'b0, r, a);
      start();
      bytex({CCS_DEV_ADDR, 1'b1}, 1'b0, r, a);
      bytex(8'hff, 1'b0, d, a);
      stop();
   endtask
   // two data bytes in one transfer, pointer advances between them
   task automatic wr2(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
      output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      start();
      bytex({CCS_DEV_ADDR, 1'b0}, 1'b0, r, a0);
      bytex(ptr, 1'b0, r, a1);
      bytex(d0, 1'b0, r, a2);
      bytex(d1, 1'b0, r, a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask
   task automatic rd2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
      logic [7:0] r;
      logic a;
      start();
      bytex({CCS_DEV_ADDR, 1'b0}, 1'b0, r, a);
      bytex(ptr, 1'b0, r, a);
      start();
      bytex({CCS_DEV_ADDR, 1'b1}, 1'b0, r, a);
      bytex(8'hff, 1'b1, d0, a);
      bytex(8'hff, 1'b0, d1, a);
      stop();
   endtask
endmodule

// [verification/tb_ccs_charge_current_regs.sv]
// testbench: drives the current register bank through the host model, checks targets
// assumes: 50 MHz clock; data wire pulled up, low while either side pulls it
`timescale 1ns/1ps
module tb_ccs_charge_current_regs
   import ccs_pkg::*;
   ;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic scl, sdaLow, sdaOut, sdaOeN, sda;
   ccs_currents_t currents;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   assign sda = !sdaLow && (sdaOeN || sdaOut);
   ccs_charge_current_regs dut (.clk(clk), .resetn(resetn), .scl(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN), .currents(currents));
   ccs_host_model host (.clk(clk), .scl(scl), .sdaLow(sdaLow), .sda(sda));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         $display("[ERR] run length expected below %0d seen %0d", 60000, cycles);
         finish_test();
      end
   end
   task automatic do_reset();
      resetn = 1'b0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
   endtask
   task automatic put(input logic [7:0] ofs, input logic [7:0] d);
      logic ok;
      host.wr(CCS_DEV_ADDR, ofs, d, ok);
      chk("write ack", 16'h1, {15'h0, ok});
   endtask
   task automatic get(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(ofs, d);
      chk("readback", {8'h0, exp}, {8'h0, d});
   endtask
   task automatic targets(input int f, input int p, input int t);
      chk("fastMa", 16'(f), {3'h0, currents.fastMa});
      chk("prechgMa", 16'(p), {3'h0, currents.prechgMa});
      chk("termMa", 16'(t), {3'h0, currents.termMa});
   endtask
   task automatic test_defaults();
      targets(1024, 256, 256);
      get(CCS_OFS_FAST, 8'h20);
      get(CCS_OFS_PT, 8'h11);
   endtask
   task automatic test_fast_codes();
      logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h15, 6'h3f};
      foreach (codes[i]) begin
         put(CCS_OFS_FAST, {codes[i], 2'b10});
         get(CCS_OFS_FAST, {codes[i], 2'b10});
         targets(512 + 64 * codes[i], 256, 256);
      end
   endtask
   task automatic test_pt_codes();
      logic [7:0] vals [3] = '{8'h00, 8'hff, 8'h5a};
      foreach (vals[i]) begin
         put(CCS_OFS_PT, vals[i]);
         get(CCS_OFS_PT, vals[i]);
         targets(4544, 128 + 128 * vals[i][7:4], 128 + 128 * vals[i][3:0]);
      end
   endtask
   task automatic test_force();
      put(CCS_OFS_FAST, 8'h21);
      put(CCS_OFS_PT, 8'h37);
      targets(1024 / 5, 512 / 2, 1024);
      put(CCS_OFS_FAST, 8'h20);
      targets(1024, 512, 1024);
   endtask
   task automatic test_bad_addr();
      logic ok;
      host.wr(7'h6a, CCS_OFS_FAST, 8'hff, ok);
      chk("foreign ack", 16'h0, {15'h0, ok});
      get(CCS_OFS_FAST, 8'h20);
      get(8'h05, 8'h00);
   endtask
   task automatic test_burst();
      logic ok;
      logic [7:0] d0, d1;
      host.wr2(CCS_OFS_FAST, 8'h4c, 8'h23, ok);
      chk("burst write ack", 16'h1, {15'h0, ok});
      host.rd2(CCS_OFS_FAST, d0, d1);
      chk("burst read 0", 16'h004c, {8'h0, d0});
      chk("burst read 1", 16'h0023, {8'h0, d1});
      targets(512 + 64 * 19, 128 + 128 * 2, 128 + 128 * 3);
   endtask
   task automatic test_rereset();
      put(CCS_OFS_PT, 8'hff);
      do_reset();
      test_defaults();
   endtask
   initial begin
      do_reset();
      test_defaults();
      test_fast_codes();
      test_pt_codes();
      test_force();
      test_bad_addr();
      test_burst();
      test_rereset();
      finish_test();
   end
endmodule
